// File: core/rfd_driver_ctrl.sv
// Purpose: Driver mode, amplitude and modulation control over APB
// Assumes: pclk at 125 MHz; carrier clock is an enable from a divider
// Notes: No wait state on any APB access; outputs all registered
//
// Implementation choice: the APB interface to the registers.
module rfd_driver_ctrl
	import rfd_pkg::*;
#(
	parameter int CARRIER_DIV = RFD_CARRIER_DIV
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Modulation sources
	input wire logic internal_envelope_signal,
	input wire logic external_signal_input,
	// Driver pins
	output logic driver_pin_one_o,
	output logic driver_pin_one_oe,
	output logic driver_pin_two_o,
	output logic driver_pin_two_oe,
	// Analogue settings
	output logic [1:0] carrier_level_reduction,
	output logic carrier_full_swing,
	output logic [4:0] residual_carrier,
	output logic overshoot_active
);

	// ==========================================================
	// Parameter check
	generate
		if (CARRIER_DIV < 2 || CARRIER_DIV > 16) begin : g_bad_div
			$error("CARRIER_DIV must lie in 2..16");
		end
	endgenerate

	localparam logic [3:0] DIV_LAST = 4'(CARRIER_DIV - 1);

	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] amp;
		logic [7:0] modc;
		logic [1:0] ext_sync;
		logic [3:0] div;
		logic mod_prev;
		logic [3:0] ovs;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic p1;
		logic p1_oe;
		logic p2;
		logic p2_oe;
		logic [1:0] level;
		logic full;
		logic [4:0] resid;
		logic ovs_act;
	} rfd_state_t;

	rfd_state_t s;
	rfd_state_t next_s;

	// ==========================================================
	// Field views
	logic inv1;
	logic inv2;
	logic drv_en;
	logic [2:0] style;
	logic [1:0] src_sel;
	logic mod_inv;
	logic [3:0] ovs_len;
	logic tick;
	logic src;
	logic mod;
	logic mod_fall;
	logic mod_drv;
	logic ovs_start;
	logic gated;
	logic v1;
	logic v2;

	assign inv1 = s.mode[RFD_B_INV1];
	assign inv2 = s.mode[RFD_B_INV2];
	assign drv_en = s.mode[RFD_B_EN];
	assign style = s.mode[RFD_B_STYLE +: 3];
	assign src_sel = s.modc[RFD_B_SRC +: 2];
	assign mod_inv = s.modc[RFD_B_MINV];
	assign ovs_len = s.modc[RFD_B_OVS +: 4];
	assign tick = (s.div == DIV_LAST);

	// Source select, reserved code gives no modulation
	always_comb begin
		unique case (src_sel)
			RFD_SRC_ENV: src = internal_envelope_signal;
			RFD_SRC_EXT: src = s.ext_sync[1];
			default: src = 1'b0;
		endcase
	end

	// Invert, stretch, gate and per-pin invert
	assign mod = src ^ mod_inv;
	assign mod_fall = s.mod_prev & ~mod;
	// Stretch must cover the fall cycle itself, before the counter loads
	assign ovs_start = mod_fall & (ovs_len != 4'h0);
	assign mod_drv = mod | ovs_start | (s.ovs != 4'h0);
	assign gated = mod_drv & drv_en;
	assign v1 = gated ^ inv1;
	assign v2 = gated ^ inv2;

	// ==========================================================
	// APB decode
	logic setup;
	logic access;
	logic hit;
	logic [7:0] rd_byte;

	assign setup = psel & ~penable;
	assign access = psel & penable & s.pready;

	always_comb begin
		hit = 1'b1;
		unique case (paddr)
			RFD_ADDR_MODE: rd_byte = s.mode & RFD_MASK_MODE;
			RFD_ADDR_AMP: rd_byte = s.amp & RFD_MASK_AMP;
			RFD_ADDR_MOD: rd_byte = s.modc & RFD_MASK_MOD;
			default: begin
				rd_byte = 8'h00;
				hit = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_s = s;
		next_s.ext_sync = {s.ext_sync[0], external_signal_input};

		// Carrier clock divider
		next_s.div = tick ? 4'h0 : s.div + 4'h1;

		// Bus answer one cycle after setup
		next_s.pready = setup;
		if (setup) begin
			next_s.prdata = {24'h000000, rd_byte};
			next_s.pslverr = ~hit;
		end

		// Register writes, reserved bits dropped
		if (access && pwrite && hit) begin
			unique case (paddr)
				RFD_ADDR_MODE: next_s.mode = pwdata[7:0] & RFD_MASK_MODE;
				RFD_ADDR_AMP: next_s.amp = pwdata[7:0] & RFD_MASK_AMP;
				default: next_s.modc = pwdata[7:0] & RFD_MASK_MOD;
			endcase
		end

		// Overshoot stretch counted in carrier clocks
		next_s.mod_prev = mod;
		if (mod_fall) begin
			next_s.ovs = ovs_len;
		end else if (tick && s.ovs != 4'h0) begin
			next_s.ovs = s.ovs - 4'h1;
		end
		next_s.ovs_act = (next_s.ovs != 4'h0);

		// Pin drive by output style
		next_s.p1 = v1;
		next_s.p2 = v2;
		next_s.p1_oe = drv_en;
		next_s.p2_oe = drv_en;
		unique case (style)
			RFD_ST_PUSHPULL: begin
			end
			RFD_ST_OPENDRAIN: begin
				next_s.p1 = 1'b0;
				next_s.p2 = 1'b0;
				next_s.p1_oe = drv_en & ~v1;
				next_s.p2_oe = drv_en & ~v2;
			end
			RFD_ST_LOW: begin
				next_s.p1 = 1'b0;
				next_s.p2 = 1'b0;
			end
			RFD_ST_HIGH: begin
				next_s.p1 = 1'b1;
				next_s.p2 = 1'b1;
			end
			default: begin
				next_s.p1_oe = 1'b0;
				next_s.p2_oe = 1'b0;
			end
		endcase

		// Amplitude settings, full swing masks the level
		next_s.full = s.modc[RFD_B_FULL];
		next_s.level = s.modc[RFD_B_FULL] ? 2'h0 : s.amp[RFD_B_LEVEL +: 2];
		next_s.resid = s.amp[RFD_B_RESID +: 5];
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.mode <= RFD_RST_MODE;
			s.amp <= RFD_RST_AMP;
			s.modc <= RFD_RST_MOD;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign driver_pin_one_o = s.p1;
	assign driver_pin_one_oe = s.p1_oe;
	assign driver_pin_two_o = s.p2;
	assign driver_pin_two_oe = s.p2_oe;
	assign carrier_level_reduction = s.level;
	assign carrier_full_swing = s.full;
	assign residual_carrier = s.resid;
	assign overshoot_active = s.ovs_act;

	// ==========================================================
	// Assertions
	localparam int OVS_MAX = 1000;

	sequence s_wr_mode;
		access && pwrite && paddr == RFD_ADDR_MODE;
	endsequence

	sequence s_fall_long;
		mod_fall && ovs_len != 4'h0;
	endsequence

	property p_setup_answer;
		@(posedge pclk) disable iff (!presetn)
		setup |=> pready ##1 !pready;
	endproperty
	a_setup_answer: assert property (p_setup_answer)
		else $error("setup not answered in one cycle");

	property p_wr_mask;
		@(posedge pclk) disable iff (!presetn)
		s_wr_mode |=> s.mode == ($past(pwdata[7:0]) & RFD_MASK_MODE);
	endproperty
	a_wr_mask: assert property (p_wr_mask)
		else $error("mode write wrong");

	property p_pin_two;
		@(posedge pclk) disable iff (!presetn)
		drv_en && style == RFD_ST_PUSHPULL |=>
			driver_pin_two_o == ($past(mod_drv) ^ $past(inv2));
	endproperty
	a_pin_two: assert property (p_pin_two)
		else $error("pin two level wrong");

	property p_pin_one;
		@(posedge pclk) disable iff (!presetn)
		drv_en && style == RFD_ST_PUSHPULL |=>
			driver_pin_one_o == ($past(mod_drv) ^ $past(inv1));
	endproperty
	a_pin_one: assert property (p_pin_one)
		else $error("pin one level wrong");

	property p_disable;
		@(posedge pclk) disable iff (!presetn)
		!drv_en |=> !driver_pin_one_oe && !driver_pin_two_oe;
	endproperty
	a_disable: assert property (p_disable)
		else $error("pins driven while disabled");

	property p_hiz;
		@(posedge pclk) disable iff (!presetn)
		style == RFD_ST_HIZ |=> !driver_pin_one_oe && !driver_pin_two_oe;
	endproperty
	a_hiz: assert property (p_hiz)
		else $error("pins driven in high impedance style");

	property p_level;
		@(posedge pclk) disable iff (!presetn)
		!s.modc[RFD_B_FULL] |=>
			carrier_level_reduction == $past(s.amp[7:6]) && !carrier_full_swing;
	endproperty
	a_level: assert property (p_level)
		else $error("level code wrong");

	property p_resid;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> residual_carrier == $past(s.amp[4:0]);
	endproperty
	a_resid: assert property (p_resid)
		else $error("residual carrier wrong");

	property p_full;
		@(posedge pclk) disable iff (!presetn)
		s.modc[RFD_B_FULL] |=> carrier_full_swing && carrier_level_reduction == 2'h0;
	endproperty
	a_full: assert property (p_full)
		else $error("full swing not applied");

	property p_inv;
		@(posedge pclk) disable iff (!presetn)
		src_sel == RFD_SRC_NONE && s.ovs == 4'h0 && !ovs_start |->
			mod_drv == mod_inv;
	endproperty
	a_inv: assert property (p_inv)
		else $error("modulation invert wrong");

	property p_reserved_src;
		@(posedge pclk) disable iff (!presetn)
		src_sel == 2'h3 |-> src == 1'b0;
	endproperty
	a_reserved_src: assert property (p_reserved_src)
		else $error("reserved source not idle");

	property p_overshoot;
		@(posedge pclk) disable iff (!presetn)
		s_fall_long |=> overshoot_active ##[1:OVS_MAX] !overshoot_active;
	endproperty
	a_overshoot: assert property (p_overshoot)
		else $error("overshoot stretch wrong");

	property p_gate;
		@(posedge pclk) disable iff (!presetn)
		!drv_en |-> gated == 1'b0;
	endproperty
	a_gate: assert property (p_gate)
		else $error("modulation not gated by enable");

	property p_stretch_hold;
		@(posedge pclk) disable iff (!presetn)
		ovs_start && drv_en && style == RFD_ST_PUSHPULL |=>
			driver_pin_one_o == !$past(inv1);
	endproperty
	a_stretch_hold: assert property (p_stretch_hold)
		else $error("stretch gap at modulation fall");

endmodule

// File: core/rfd_pkg.sv
// Purpose: Constants for the RF driver modulation control block
// Assumes: APB byte address is four times the register index
// Notes: Output style and reset codes are fixed here only
//
// Functional notes
// - Driver-2 invert set puts the inverse of driver signal 2 on pin two.
// - Driver-1 invert set puts the inverse of driver signal 1 on pin one.
// - Output enable one enables both driver pins, zero disables both.
// - A 3-bit style field picks drive style; codes 011b, 110b unusable.
// - A 2-bit level field picks 100, 250, 500 or 1000 mV reduction.
// - Amplitude bits 4 to 0 set the residual carrier percentage.
// - Full-swing set drives maximum carrier and ignores the level field.
// - Modulation invert set inverts the selected modulation source.
// - Source field: 00 none, 01 envelope, 10 external input, 11 reserved.
// - Bits 7 to 4 give extra modulation length in carrier clocks.
package rfd_pkg;

	// ==========================================================
	// Register indices and byte addresses
	localparam logic [7:0] RFD_IDX_MODE = 8'h28;
	localparam logic [7:0] RFD_IDX_AMP = 8'h29;
	localparam logic [7:0] RFD_IDX_MOD = 8'h2a;
	localparam logic [11:0] RFD_ADDR_MODE = {2'h0, RFD_IDX_MODE, 2'h0};
	localparam logic [11:0] RFD_ADDR_AMP = {2'h0, RFD_IDX_AMP, 2'h0};
	localparam logic [11:0] RFD_ADDR_MOD = {2'h0, RFD_IDX_MOD, 2'h0};

	// ==========================================================
	// Reset values and writable masks
	localparam logic [7:0] RFD_RST_MODE = 8'h00;
	localparam logic [7:0] RFD_RST_AMP = 8'h00;
	localparam logic [7:0] RFD_RST_MOD = 8'h00;
	localparam logic [7:0] RFD_MASK_MODE = 8'hcf;
	localparam logic [7:0] RFD_MASK_AMP = 8'hdf;
	localparam logic [7:0] RFD_MASK_MOD = 8'hff;

	// ==========================================================
	// Field positions
	localparam int RFD_B_INV2 = 7;
	localparam int RFD_B_INV1 = 6;
	localparam int RFD_B_EN = 3;
	localparam int RFD_B_STYLE = 0;
	localparam int RFD_B_LEVEL = 6;
	localparam int RFD_B_RESID = 0;
	localparam int RFD_B_OVS = 4;
	localparam int RFD_B_FULL = 3;
	localparam int RFD_B_MINV = 2;
	localparam int RFD_B_SRC = 0;

	// ==========================================================
	// Output style codes
	localparam logic [2:0] RFD_ST_PUSHPULL = 3'h0;
	localparam logic [2:0] RFD_ST_OPENDRAIN = 3'h1;
	localparam logic [2:0] RFD_ST_HIZ = 3'h2;
	localparam logic [2:0] RFD_ST_LOW = 3'h4;
	localparam logic [2:0] RFD_ST_HIGH = 3'h5;

	// ==========================================================
	// Modulation source codes
	localparam logic [1:0] RFD_SRC_NONE = 2'h0;
	localparam logic [1:0] RFD_SRC_ENV = 2'h1;
	localparam logic [1:0] RFD_SRC_EXT = 2'h2;

	// Carrier clock period in ns, pclk period in ns and the divider between them
	localparam int RFD_CARRIER_NS = 72;
	localparam int RFD_PCLK_NS = 8;
	localparam int RFD_CARRIER_DIV = RFD_CARRIER_NS / RFD_PCLK_NS;

endpackage

// File: bench/rfd_antenna_model.sv
// Purpose: Antenna network seen from the two driver pins
// Assumes: A released pin has no pull, so its level is not the last one
// Notes: Coil levels are what the bench compares against the pins
module rfd_antenna_model (
	// Clock
	input wire logic pclk,
	// Driver pins
	input wire logic pin_one_o,
	input wire logic pin_one_oe,
	input wire logic pin_two_o,
	input wire logic pin_two_oe,
	// Coil levels
	output logic coil_one,
	output logic coil_two
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_one = 1'b0;
	logic last_two = 1'b0;
	// ==========================================
	// Floating pin shows the inverse of its last driven level
	always_ff @(posedge pclk) begin
		if (pin_one_oe)
			last_one <= pin_one_o;
		if (pin_two_oe)
			last_two <= pin_two_o;
	end
	assign coil_one = pin_one_oe ? pin_one_o : ~last_one;
	assign coil_two = pin_two_oe ? pin_two_o : ~last_two;
endmodule

// File: bench/rf_driver_modulation_control_tb_top.sv
// Purpose: Self-checking bench for the driver modulation control block
// Assumes: APB slave answers in its own time, carrier divider set to 2
// Notes: Pin levels are sampled three to five edges after the settings change
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
	err_count++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module rf_driver_modulation_control_tb_top;
	import rfd_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, env = 1'b0, ext = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, p1, p1e, p2, p2e, full, ovs, c1, c2;
	logic [1:0] lvl;
	logic [4:0] resid;
	int err_count = 0, check_count = 0;
	logic [31:0] rd;
	logic er;
	// ==========================================
	// Clock, design and antenna
	always #4 pclk = ~pclk;
	rfd_driver_ctrl #(.CARRIER_DIV(2)) dut_u (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .internal_envelope_signal(env),
		.external_signal_input(ext), .driver_pin_one_o(p1),
		.driver_pin_one_oe(p1e), .driver_pin_two_o(p2),
		.driver_pin_two_oe(p2e), .carrier_level_reduction(lvl),
		.carrier_full_swing(full), .residual_carrier(resid),
		.overshoot_active(ovs));
	rfd_antenna_model ant_u (.pclk(pclk), .pin_one_o(p1),
		.pin_one_oe(p1e), .pin_two_o(p2), .pin_two_oe(p2e),
		.coil_one(c1), .coil_two(c2));
	// ==========================================
	// One APB transfer, held until pready is seen high
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [7:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// ==========================================
	// Reset values, writable masks, unmapped access
	task automatic t_regs();
		logic [11:0] ad[3] = '{RFD_ADDR_MODE, RFD_ADDR_AMP, RFD_ADDR_MOD};
		logic [7:0] mk[3] = '{8'hcf, 8'hdf, 8'hff};
		for (int i = 0; i < 3; i++) begin
			apb(ad[i], 1'b0, 8'h00);
			`CHK("reset", 32'h0, rd)
			apb(ad[i], 1'b1, 8'hff);
			apb(ad[i], 1'b0, 8'h00);
			`CHK("mask", {24'h0, mk[i]}, rd)
			apb(ad[i], 1'b1, 8'h00);
		end
		apb(12'h0b0, 1'b1, 8'h55);
		`CHK("werr", 1'b1, er)
		apb(12'h0b0, 1'b0, 8'h00);
		`CHK("rerr", 1'b1, er)
		`CHK("rdat", 32'h0, rd)
	endtask
	// ==========================================
	// Level codes, residual carrier and full swing
	task automatic t_amp();
		for (int i = 0; i < 4; i++) begin
			apb(RFD_ADDR_AMP, 1'b1, {i[1:0], 6'h15});
			settle(2);
			`CHK("level", i[1:0], lvl)
			`CHK("resid", 5'h15, resid)
			`CHK("full0", 1'b0, full)
			apb(RFD_ADDR_MOD, 1'b1, 8'h08);
			settle(2);
			`CHK("fslvl", 2'h0, lvl)
			`CHK("full", 1'b1, full)
			apb(RFD_ADDR_MOD, 1'b1, 8'h00);
		end
	endtask
	// ==========================================
	// Every source and invert setting, pin inversion on and off
	task automatic t_pins(input logic [7:0] mode);
		logic s, m;
		apb(RFD_ADDR_MODE, 1'b1, mode);
		for (int k = 0; k < 16; k++) begin
			apb(RFD_ADDR_MOD, 1'b1, {5'h0, k[2:0]});
			env <= k[3];
			ext <= ~k[3];
			settle(5);
			s = (k[1:0] == 2'h1) ? k[3] : (k[1:0] == 2'h2) ? ~k[3] : 1'b0;
			m = s ^ k[2];
			`CHK("pin1", m ^ mode[6], p1)
			`CHK("pin2", m ^ mode[7], p2)
			`CHK("coil1", m ^ mode[6], c1)
			`CHK("coil2", m ^ mode[7], c2)
			`CHK("oe", 2'h3, {p1e, p2e})
		end
	endtask
	// ==========================================
	// Drivers off when disabled or in high impedance style
	task automatic t_off(input logic [7:0] mode);
		apb(RFD_ADDR_MODE, 1'b1, mode);
		settle(3);
		`CHK("off", 2'h0, {p1e, p2e})
	endtask
	// ==========================================
	// Open drain, forced levels and unusable style codes
	task automatic t_style();
		logic [2:0] st[5] = '{RFD_ST_OPENDRAIN, RFD_ST_LOW, RFD_ST_HIGH,
			3'h3, 3'h6};
		logic [1:0] eo, ee;
		for (int i = 0; i < 5; i++) begin
			for (int v = 0; v < 2; v++) begin
				apb(RFD_ADDR_MOD, 1'b1, {5'h0, v[0], 2'h0});
				apb(RFD_ADDR_MODE, 1'b1, {5'h01, st[i]});
				settle(3);
				eo = (i == 2) ? 2'h3 : 2'h0;
				ee = (i == 0) ? {2{~v[0]}} : (i < 3) ? 2'h3 : 2'h0;
				if (i < 3) `CHK("style_o", eo, {p1, p2})
				`CHK("style_oe", ee, {p1e, p2e})
				if (i == 0) `CHK("odcoil", {2{v[0]}}, {c1, c2})
			end
		end
	endtask
	// ==========================================
	// Reset in mid-run returns registers and pins to idle
	task automatic t_reset();
		apb(RFD_ADDR_MODE, 1'b1, 8'hc8);
		apb(RFD_ADDR_AMP, 1'b1, 8'hdf);
		settle(2);
		presetn <= 1'b0;
		settle(2);
		`CHK("rst_oe", 2'h0, {p1e, p2e})
		`CHK("rst_res", 5'h00, resid)
		presetn <= 1'b1;
		@(posedge pclk);
		apb(RFD_ADDR_MODE, 1'b0, 8'h00);
		`CHK("rst_mode", {24'h0, RFD_RST_MODE}, rd)
		apb(RFD_ADDR_AMP, 1'b0, 8'h00);
		`CHK("rst_amp", {24'h0, RFD_RST_AMP}, rd)
	endtask
	// ==========================================
	// Overshoot stretch after the modulation falls
	task automatic t_ovs();
		int n;
		apb(RFD_ADDR_MODE, 1'b1, 8'h08);
		apb(RFD_ADDR_MOD, 1'b1, 8'h21);
		env <= 1'b1;
		settle(4);
		env <= 1'b0;
		n = 0;
		for (int i = 0; i < 12; i++) begin
			@(posedge pclk);
			if (ovs === 1'b1) begin
				n++;
				`CHK("hold", 1'b1, p1)
			end
		end
		// Two carrier clocks of two pclk each; first tick phase is open
		`CHK("stretch", 1'b1, n >= 3 && n <= 4)
		`CHK("end", 1'b0, p1)
	endtask
	// ==========================================
	// Verdict, counts and end of run
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Watchdog for a hung handshake
	initial begin
		#200000;
		err_count++;
		complete_run();
	end
	// Main sequence
	initial begin
		settle(4);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_amp();
		t_pins(8'h08);
		t_pins(8'hc8);
		t_pins(8'h48);
		t_off(8'h00);
		t_off(8'h0a);
		t_style();
		t_reset();
		t_ovs();
		complete_run();
	end
endmodule
